// File: rtl/usrt_status.sv
// usrt_status: mode, mask, channel status and holding registers of a serial transceiver.
// assumes the shifter and line logic sit outside and report events as one-cycle pulses.
// How it works
// RULE1: mode field picks one of nine operating modes
// RULE2: clock-source field picks module, divided or external clock
// RULE3: mask-set write sets mask bits written one
// RULE4: mask-clear write clears mask bits written one
// RULE5: mask readable; irq only for enabled flags
// RULE6: manchester enable mirrored at bits 20 and 24
// RULE7: status shows live modem input levels
// RULE8: modem change flags sticky until status read
// RULE9: manchester fault sticky until status reset
// RULE10: nack flag sticky until nack reset
// RULE11: rx dma full mirrored live
// RULE12: bit 10 repeat limit or spi-slave underrun
// RULE13: tx empty needs holding and shifter empty
// RULE14: timeout flag sets, zero when timeout off
// RULE15: framing flag sticky until status reset
// RULE16: parity, overrun, break flags sticky likewise
// RULE17: tx ready low when busy, break, disabled
// RULE18: rx ready set on char, cleared by read
// RULE19: rx holding gives char and command marker
// RULE20: tx holding write queues char and marker
// RULE21: software writes tx holding only when ready
// RULE22: status reset clears five error flags together; code clears six, repeat limit included
// RULE23: change during status read is not lost
`timescale 1ns/10ps
module usrt_status
    import usrt_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [31:0]   rdata,
    input  wire usrt_line_ev_t line_ev,
    input  wire usrt_modem_t   modem_in,
    input  wire logic          rx_dma_full,
    input  wire logic          tx_shift_busy,
    input  wire logic          tx_take,
    output usrt_txchar_t       tx_char,
    output logic               tx_char_valid,
    output logic               begin_break_pend,
    output logic               arm_idle_timer_cmd,
    output logic               clear_nack_cmd,
    output usrt_mode_t         op_mode,
    output usrt_clksel_t       clock_source_sel,
    output logic [1:0]         char_length_sel,
    output logic               rx_enabled,
    output logic               tx_enabled,
    output logic [15:0]        timeout_value,
    output logic               irq
);
    logic [31:0]  mode_r;
    logic [31:0]  mask_r;
    logic [31:0]  mask_nxt;
    logic         rx_en_r;
    logic         tx_en_r;
    logic [15:0]  tmo_r;
    logic [3:0]   modem_prev_r;
    logic [3:0]   chg_r;
    logic         manchester_fault_flag;
    logic         nack_r;
    logic         iter_r;
    logic         tmo_flag_r;
    logic         frame_r;
    logic         parity_fault;
    logic         overrun_fault;
    logic         break_seen;
    logic         rx_char_avail;
    logic [9:0]   rx_hold_r;
    logic         hold_full_r;
    usrt_txchar_t tx_hold_r;
    logic         brk_r;
    logic         tx_slot_free;
    logic         tx_all_drained;
    logic [31:0]  status;
    logic [3:0]   modem_now;

    // address compare used by every register process except the read-data case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    wire wr_ctrl   = wr & hit(addr, OFF_CTRL);
    wire rd_status = rd & hit(addr, OFF_STATUS);
    wire rst_sta   = wr_ctrl & wdata[C_CLRSTA];
    assign modem_now = {modem_in.cts, modem_in.dcd, modem_in.dsr, modem_in.ri};

    // mode register: mode, clock source, length
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_r <= MODE_RST;
            tmo_r  <= TMO_RST;
        end else begin
            if (wr & hit(addr, OFF_MODE)) begin
                mode_r <= wdata;
            end
            if (wr & hit(addr, OFF_TIMEOUT)) begin
                tmo_r <= wdata[15:0];
            end
        end
    end
    // RULE1: reserved codes pass through unchanged
    assign op_mode          = usrt_mode_t'(mode_r[3:0]);
    // RULE2: clock source selection field
    assign clock_source_sel = usrt_clksel_t'(mode_r[5:4]);
    assign char_length_sel  = mode_r[7:6];
    assign timeout_value    = tmo_r;

    // mask set and clear; bit 24 folds onto 20
    always_comb begin
        mask_nxt = mask_r;
        if (wr & hit(addr, OFF_IRQ_SET)) begin
            // RULE3: set on ones
            mask_nxt = mask_r | (wdata & MASK_VALID);
            // RULE6: alias position acts the same
            mask_nxt[B_MANA] = mask_r[B_MANA] | wdata[B_MAN] | wdata[B_MANA];
        end
        if (wr & hit(addr, OFF_IRQ_CLR)) begin
            // RULE4: clear on ones
            mask_nxt = mask_r & ~wdata;
            mask_nxt[B_MANA] = mask_r[B_MANA] & ~(wdata[B_MAN] | wdata[B_MANA]);
        end
        mask_nxt[B_MAN] = 1'b0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_r <= MASK_RST;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // enables and self-clearing command pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            if (wdata[C_RXDIS]) begin
                rx_en_r <= 1'b0;
            end else if (wdata[C_RXEN]) begin
                rx_en_r <= 1'b1;
            end
            if (wdata[C_TXDIS]) begin
                tx_en_r <= 1'b0;
            end else if (wdata[C_TXEN]) begin
                tx_en_r <= 1'b1;
            end
        end
    end
    assign rx_enabled         = rx_en_r;
    assign tx_enabled         = tx_en_r;
    assign arm_idle_timer_cmd = wr_ctrl & wdata[C_ARM];
    assign clear_nack_cmd     = wr_ctrl & wdata[C_RSTNAK];

    // modem change flags; set beats read clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modem_prev_r <= 4'h0;
            chg_r        <= 4'h0;
        end else begin
            modem_prev_r <= modem_now;
            // RULE8: sticky until status read
            // RULE23: fresh change survives the read
            chg_r <= (rd_status ? 4'h0 : chg_r) | (modem_now ^ modem_prev_r);
        end
    end

    // error flags; event wins over status reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            manchester_fault_flag <= 1'b0;
            frame_r               <= 1'b0;
            parity_fault          <= 1'b0;
            overrun_fault         <= 1'b0;
            break_seen            <= 1'b0;
            iter_r                <= 1'b0;
            nack_r                <= 1'b0;
        end else begin
            // RULE22: six flags cleared together
            // RULE9: manchester sticky
            manchester_fault_flag <= (manchester_fault_flag & ~rst_sta) | line_ev.manchester_fault;
            // RULE15: framing sticky
            frame_r       <= (frame_r & ~rst_sta) | line_ev.framing_fault;
            // RULE16: parity, overrun, break sticky
            parity_fault  <= (parity_fault & ~rst_sta) | line_ev.parity_fault;
            overrun_fault <= (overrun_fault & ~rst_sta) | line_ev.overrun_fault;
            break_seen    <= (break_seen & ~rst_sta) | line_ev.break_seen;
            // RULE12: meaning follows spi-slave mode
            iter_r <= (iter_r & ~rst_sta) | ((op_mode == USRT_SPI_S) ? line_ev.underrun
                                                                     : line_ev.repeat_limit);
            // RULE10: nack sticky until nack reset
            nack_r <= (nack_r & ~clear_nack_cmd) | line_ev.nack_seen;
        end
    end

    // timeout flag: rearm clears, expiry sets
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmo_flag_r <= 1'b0;
        end else begin
            // RULE14: set on expiry since arm
            tmo_flag_r <= ((tmo_flag_r & ~arm_idle_timer_cmd) | line_ev.timeout)
                          & (tmo_r != 16'h0000);
        end
    end

    // receive holding; data kept while disabled so ready returns on enable
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_hold_r   <= 10'h000;
            hold_full_r <= 1'b0;
        end else begin
            if (line_ev.rx_done) begin
                rx_hold_r   <= {line_ev.rx_cmd, line_ev.rx_char};
                hold_full_r <= 1'b1;
            end else if (rd & hit(addr, OFF_RX_HOLD)) begin
                hold_full_r <= 1'b0;
            end
        end
    end
    // RULE18: ready masked while disabled
    assign rx_char_avail = hold_full_r & rx_en_r;

    // transmit holding and break request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_hold_r     <= '0;
            tx_char_valid <= 1'b0;
            brk_r         <= 1'b0;
        end else begin
            // RULE20: queue char and sync marker
            if (wr & hit(addr, OFF_TX_HOLD)) begin
                tx_hold_r     <= {wdata[B_SYNH], wdata[8:0]};
                tx_char_valid <= 1'b1;
            end else if (tx_take) begin
                tx_char_valid <= 1'b0;
            end
            if (wr_ctrl & wdata[C_BRK]) begin
                brk_r <= 1'b1;
            end else if (~tx_char_valid & ~tx_shift_busy) begin
                brk_r <= 1'b0;
            end
        end
    end
    assign tx_char          = tx_hold_r;
    assign begin_break_pend = brk_r;
    // RULE17: ready needs enable, empty slot, no break
    assign tx_slot_free   = tx_en_r & ~tx_char_valid & ~brk_r;
    // RULE13: both stages empty and enabled
    assign tx_all_drained = tx_en_r & ~tx_char_valid & ~tx_shift_busy;

    // channel status assembly
    always_comb begin
        status = 32'h0000_0000;
        status[B_RXAV]  = rx_char_avail;
        status[B_TXFR]  = tx_slot_free;
        status[B_BRK]   = break_seen;
        status[B_OVR]   = overrun_fault;
        status[B_FRAME] = frame_r;
        status[B_PAR]   = parity_fault;
        status[B_TMO]   = tmo_flag_r;
        status[B_TXEMP] = tx_all_drained;
        status[B_ITER]  = iter_r;
        // RULE11: live mirror
        status[B_RXBUF] = rx_dma_full;
        status[B_NACK]  = nack_r;
        status[B_CHG_LO+3:B_CHG_LO] = chg_r;
        // RULE7: live modem levels
        status[B_IMG_LO+3:B_IMG_LO] = modem_now;
        status[B_MAN]   = manchester_fault_flag;
    end

    // RULE5: irq from enabled flags only; manchester via folded bit
    assign irq = |(status[15:0] & mask_r[15:0]) | |(chg_r & mask_r[19:16])
               | (manchester_fault_flag & mask_r[B_MANA]);

    // read data, one cycle after strobe; unmapped reads zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                OFF_MODE:     rdata <= mode_r;
                // RULE6: both positions read the same
                OFF_IRQ_MASK: rdata <= mask_r | ({31'h0, mask_r[B_MANA]} << B_MAN);
                OFF_STATUS:   rdata <= status;
                // RULE19: char plus command marker at 15
                OFF_RX_HOLD:  rdata <= {16'h0000, rx_hold_r[9], 6'h00, rx_hold_r[8:0]};
                OFF_TIMEOUT:  rdata <= {16'h0000, tmo_r};
                default:      rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // chk_ properties
    chk_mask_set_alias: assert property (@(posedge mclk) disable iff (rst) // RULE6
        (wr && addr == OFF_IRQ_SET && wdata[B_MAN]) |=> mask_r[B_MANA])
        else $error("alias enable write did not set mask");
    chk_mask_clear: assert property (@(posedge mclk) disable iff (rst) // RULE4
        (wr && addr == OFF_IRQ_CLR && wdata[B_PAR]) |=> !mask_r[B_PAR])
        else $error("mask clear ignored");
    chk_mask_set: assert property (@(posedge mclk) disable iff (rst) // RULE3
        (wr && addr == OFF_IRQ_SET && wdata[B_FRAME]) |=> mask_r[B_FRAME])
        else $error("mask set ignored");
    chk_chg_keep: assert property (@(posedge mclk) disable iff (rst) // RULE23
        (modem_now != modem_prev_r) |=> (chg_r != 4'h0))
        else $error("modem change lost");
    chk_chg_sticky: assert property (@(posedge mclk) disable iff (rst) // RULE8
        (chg_r[0] && !rd_status) |=> chg_r[0])
        else $error("change flag dropped without read");
    chk_frame_hold: assert property (@(posedge mclk) disable iff (rst) // RULE15
        (frame_r && !rst_sta) |=> frame_r)
        else $error("framing flag dropped");
    chk_sta_clear: assert property (@(posedge mclk) disable iff (rst) // RULE22
        (rst_sta && !line_ev.parity_fault && !line_ev.overrun_fault) |=>
        (!parity_fault && !overrun_fault))
        else $error("status reset missed");
    chk_tx_slot_free_off: assert property (@(posedge mclk) disable iff (rst) // RULE17
        (!tx_en_r || brk_r) |-> !status[B_TXFR])
        else $error("tx ready while blocked");
    chk_rx_read: assert property (@(posedge mclk) disable iff (rst) // RULE18
        (rd && addr == OFF_RX_HOLD && !line_ev.rx_done) |=> !rx_char_avail)
        else $error("rx ready not cleared by read");
    chk_tmo_zero: assert property (@(posedge mclk) disable iff (rst) // RULE14
        (tmo_r == 16'h0000) |=> !tmo_flag_r)
        else $error("timeout flag with zero value");
    chk_nack_hold: assert property (@(posedge mclk) disable iff (rst) // RULE10
        (nack_r && !clear_nack_cmd) |=> nack_r)
        else $error("nack flag dropped");
    chk_man_hold: assert property (@(posedge mclk) disable iff (rst) // RULE9
        (manchester_fault_flag && !rst_sta) |=> manchester_fault_flag)
        else $error("manchester flag dropped");
    chk_brk_hold: assert property (@(posedge mclk) disable iff (rst) // RULE16
        (break_seen && !rst_sta) |=> break_seen)
        else $error("break flag dropped");
endmodule : usrt_status

// File: rtl/usrt_pkg.sv
// usrt_pkg: register map, field positions and reset values for the serial status block.
// assumes a plain register port with word-aligned byte addresses.
package usrt_pkg;
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_MODE     = 8'h04;
    localparam logic [7:0] OFF_IRQ_SET  = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_STATUS   = 8'h18 - 8'h04;
    localparam logic [7:0] OFF_RX_HOLD  = 8'h18;
    localparam logic [7:0] OFF_TX_HOLD  = 8'h1c;
    localparam logic [7:0] OFF_TIMEOUT  = 8'h24;

    // status bit positions
    localparam int B_RXAV   = 0;
    localparam int B_TXFR   = 1;
    localparam int B_BRK    = 2;
    localparam int B_OVR    = 5;
    localparam int B_FRAME  = 6;
    localparam int B_PAR    = 7;
    localparam int B_TMO    = 8;
    localparam int B_TXEMP  = 9;
    localparam int B_ITER   = 10;
    localparam int B_RXBUF  = 12;
    localparam int B_NACK   = 13;
    localparam int B_CHG_LO = 16;
    localparam int B_IMG_LO = 20;
    localparam int B_MAN    = 24;
    localparam int B_MANA   = 20;
    localparam int B_SYNH   = 15;

    // control command bit positions (self-clearing pulses)
    localparam int C_CLRSTA = 8;
    localparam int C_BRK    = 9;
    localparam int C_ARM    = 11;
    localparam int C_RSTNAK = 14;
    localparam int C_RXEN   = 4;
    localparam int C_RXDIS  = 5;
    localparam int C_TXEN   = 6;
    localparam int C_TXDIS  = 7;

    localparam logic [31:0] MASK_VALID = 32'h011f_37e7;
    localparam logic [31:0] MASK_RST   = 32'h0000_0000;
    localparam logic [31:0] MODE_RST   = 32'h0000_0000;
    localparam logic [15:0] TMO_RST    = 16'h0000;

    // operating modes
    typedef enum logic [3:0] {
        USRT_NORMAL = 4'h0, USRT_RS485 = 4'h1, USRT_HSHK = 4'h2, USRT_MODEM = 4'h3,
        USRT_ISO_T0 = 4'h4, USRT_ISO_T1 = 4'h6, USRT_IRDA = 4'h8,
        USRT_SPI_M  = 4'he, USRT_SPI_S  = 4'hf
    } usrt_mode_t;

    typedef enum logic [1:0] {
        USRT_CLK_MOD = 2'b00, USRT_CLK_DIV = 2'b01, USRT_CLK_RSV = 2'b10, USRT_CLK_EXT = 2'b11
    } usrt_clksel_t;

    // line-side events, one-cycle pulses
    typedef struct packed {
        logic rx_done;
        logic rx_cmd;
        logic [8:0] rx_char;
        logic parity_fault;
        logic framing_fault;
        logic overrun_fault;
        logic break_seen;
        logic manchester_fault;
        logic nack_seen;
        logic repeat_limit;
        logic underrun;
        logic timeout;
    } usrt_line_ev_t;

    // modem input levels
    typedef struct packed {
        logic cts;
        logic dcd;
        logic dsr;
        logic ri;
    } usrt_modem_t;

    // character handed to the shifter
    typedef struct packed {
        logic       cmd;
        logic [8:0] chr;
    } usrt_txchar_t;
endpackage : usrt_pkg

// File: sim/usrt_line_model.sv
// usrt_line_model: transmit shifter standing behind the status block.
// assumes the block offers one character at a time on tx_char with tx_char_valid.
`timescale 1ns/10ps
module usrt_line_model
    import usrt_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         slow,
    input  wire logic         tx_char_valid,
    input  wire usrt_txchar_t tx_char,
    output logic              tx_take,
    output logic              tx_shift_busy,
    output usrt_txchar_t      taken_r
);
    logic       take_r;
    logic [7:0] cnt_r;

    // take a character only when idle; slow mode stands for a low baud rate
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            take_r  <= 1'b0;
            cnt_r   <= 8'h00;
            taken_r <= '0;
        end else begin
            take_r <= 1'b0;
            if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else if (tx_char_valid && !take_r) begin
                take_r  <= 1'b1;
                cnt_r   <= slow ? 8'h28 : 8'h04;
                taken_r <= tx_char;
            end
        end
    end

    // busy covers the take cycle, so no idle gap shows between take and shift
    assign tx_take       = take_r;
    assign tx_shift_busy = cnt_r != 8'h00;
endmodule : usrt_line_model

// File: sim/tb_top.sv
// tb_top: self-checking bench for the serial status block and a shifter model.
// assumes one 125 MHz clock and the register port of the package.
`timescale 1ns/10ps
module tb_top;
    import usrt_pkg::*;

    logic          mclk, rst, wr, rd, rx_dma_full, slow;
    logic          tx_take, tx_shift_busy, tx_char_valid, begin_break_pend;
    logic          arm_idle_timer_cmd, clear_nack_cmd, rx_enabled, tx_enabled, irq;
    logic [1:0]    char_length_sel, cmd_seen;
    logic [3:0]    old;
    logic [7:0]    addr;
    logic [15:0]   timeout_value;
    logic [31:0]   wdata, rdata, s, m, v;
    usrt_line_ev_t line_ev;
    usrt_modem_t   modem_in;
    usrt_txchar_t  tx_char, taken;
    usrt_txchar_t  c [3];
    usrt_mode_t    op_mode;
    usrt_clksel_t  clock_source_sel;
    logic [7:0]    ofs [7] = '{OFF_IRQ_SET, OFF_IRQ_CLR, OFF_IRQ_MASK, OFF_STATUS,
                               OFF_RX_HOLD, OFF_TX_HOLD, 8'h3c};
    logic [3:0]    modes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'he, 4'hf};
    int            mismatches, total_checks;

    usrt_status u_usrt_status (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .line_ev,
        .modem_in, .rx_dma_full, .tx_shift_busy, .tx_take, .tx_char, .tx_char_valid,
        .begin_break_pend, .arm_idle_timer_cmd, .clear_nack_cmd, .op_mode,
        .clock_source_sel, .char_length_sel, .rx_enabled, .tx_enabled, .timeout_value,
        .irq);
    usrt_line_model u_usrt_line_model (.mclk, .rst, .slow, .tx_char_valid, .tx_char,
        .tx_take, .tx_shift_busy, .taken_r(taken));

    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard, well beyond the expected run
    initial begin
        #320000;
        mismatches++;
        results();
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // write; command pulses are caught mid-cycle since they last one cycle only
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(negedge mclk);
        cmd_seen = {arm_idle_timer_cmd, clear_nack_cmd};
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        s = rdata;
    endtask : rreg

    task automatic ctl(input int b);
        wreg(OFF_CTRL, 32'h1 << b);
    endtask : ctl

    task automatic ev(input logic [19:0] e);
        @(posedge mclk);
        line_ev <= usrt_line_ev_t'(e);
        @(posedge mclk);
        line_ev <= '0;
    endtask : ev

    // bounded poll of one status bit
    task automatic waitbit(input int b);
        int n = 0;
        do begin
            rreg(OFF_STATUS);
            n++;
        end while (s[b] !== 1'b1 && n < 200);
        chk("status wait", s[b], 1'b1);
    endtask : waitbit

    // mask model: bits 20 and 24 are one enable
    task automatic mw(input logic clr, input logic [31:0] w);
        logic [31:0] a;
        a = (w[20] | w[24]) ? (w | 32'h0110_0000) : w;
        wreg(clr ? OFF_IRQ_CLR : OFF_IRQ_SET, w);
        m = clr ? (m & ~a) : ((m | a) & MASK_VALID);
        rreg(OFF_IRQ_MASK);
        chk("mask", s, m);
    endtask : mw

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    initial begin
        rst = 1'b1;
        {wr, rd, rx_dma_full, slow} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        line_ev = '0;
        modem_in = '0;
        m = 32'h0;
        void'($urandom(32'h675c));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        // reset values, write-only and unmapped reads
        foreach (ofs[i]) begin
            rreg(ofs[i]);
            chk("reset read", s, 32'h0);
        end
        $display("test reset done");
        mw(1'b0, 32'h0100_0000);
        mw(1'b1, 32'h0010_0000);
        for (int i = 0; i < 20; i++)
            mw(i[0], $urandom);
        // masked flag drives irq, unmasked does not
        mw(1'b1, 32'hffff_ffff);
        ev(20'h00100);
        @(negedge mclk);
        chk("irq off", irq, 1'b0);
        mw(1'b0, 32'h1 << B_PAR);
        @(negedge mclk);
        chk("irq on", irq, 1'b1);
        mw(1'b1, 32'h1 << B_PAR);
        $display("test mask done");
        // parity, framing, overrun, break, manchester, repeat limit
        ev(20'h001f4);
        repeat (2) rreg(OFF_STATUS);
        chk("sticky", s & 32'h0100_04e4, 32'h0100_04e4);
        ctl(C_CLRSTA);
        rreg(OFF_STATUS);
        chk("status clear", s & 32'h0100_04e4, 32'h0);
        wreg(OFF_MODE, 32'h0000_000f);
        ev(20'h00002);
        rreg(OFF_STATUS);
        chk("underrun", s[B_ITER], 1'b1);
        ev(20'h00008);
        ctl(C_CLRSTA);
        rreg(OFF_STATUS);
        chk("nack kept", s[B_NACK], 1'b1);
        ctl(C_RSTNAK);
        chk("nack cmd", cmd_seen[0], 1'b1);
        rreg(OFF_STATUS);
        chk("nack clr", {s[B_NACK], s[B_ITER]}, 2'b00);
        $display("test sticky done");
        // modem images and change flags, read clears them
        for (int i = 0; i < 8; i++) begin
            old = modem_in;
            @(posedge mclk);
            modem_in <= usrt_modem_t'(4'($urandom));
            repeat (4) @(posedge mclk);
            rreg(OFF_STATUS);
            chk("modem image", s[23:20], modem_in);
            chk("change set", s[19:16], old ^ modem_in);
            rreg(OFF_STATUS);
            chk("change clr", s[19:16], 4'h0);
        end
        @(posedge mclk);
        addr <= OFF_STATUS;
        rd <= 1'b1;
        modem_in.ri <= ~modem_in.ri;
        @(posedge mclk);
        rd <= 1'b0;
        repeat (4) @(posedge mclk);
        rreg(OFF_STATUS);
        chk("change kept", s[16], 1'b1);
        for (int i = 1; i >= 0; i--) begin
            @(posedge mclk);
            rx_dma_full <= i[0];
            rreg(OFF_STATUS);
            chk("dma full", s[B_RXBUF], i[0]);
        end
        $display("test modem done");
        ev(20'h00001);
        rreg(OFF_STATUS);
        chk("timeout off", s[B_TMO], 1'b0);
        wreg(OFF_TIMEOUT, 32'h5);
        ctl(C_ARM);
        chk("arm cmd", {cmd_seen[1], timeout_value}, 17'h10005);
        rreg(OFF_TIMEOUT);
        chk("timeout read", s, 32'h5);
        ev(20'h00001);
        rreg(OFF_STATUS);
        chk("timeout on", s[B_TMO], 1'b1);
        ctl(C_ARM);
        rreg(OFF_STATUS);
        chk("timeout rearm", s[B_TMO], 1'b0);
        foreach (modes[i]) begin
            v = {24'h0, 2'($urandom), 2'(i), modes[i]};
            wreg(OFF_MODE, v);
            @(negedge mclk);
            chk("mode", {op_mode, clock_source_sel, char_length_sel},
                {v[3:0], v[5:4], v[7:6]});
            rreg(OFF_MODE);
            chk("mode read", s, v);
        end
        wreg(OFF_MODE, 32'h0);
        $display("test mode done");
        // transmit: second character waits while the first shifts slowly
        ctl(C_TXEN);
        slow <= 1'b1;
        rreg(OFF_STATUS);
        chk("tx idle", {tx_enabled, s[B_TXEMP], s[B_TXFR]}, 3'b111);
        for (int i = 0; i < 3; i++) begin
            c[i] = usrt_txchar_t'(10'($urandom));
            waitbit(B_TXFR);
            wreg(OFF_TX_HOLD, {16'h0, c[i].cmd, 6'h0, c[i].chr});
        end
        rreg(OFF_STATUS);
        chk("tx busy", {s[B_TXEMP], s[B_TXFR], tx_char_valid}, 3'b001);
        chk("tx queued", {tx_char, taken}, {c[2], c[1]});
        waitbit(B_TXEMP);
        chk("tx sent", taken, c[2]);
        wreg(OFF_TX_HOLD, {16'h0, c[0].cmd, 6'h0, c[0].chr});
        ctl(C_BRK);
        rreg(OFF_STATUS);
        chk("break", {s[B_TXFR], begin_break_pend}, 2'b01);
        waitbit(B_TXEMP);
        ctl(C_TXDIS);
        rreg(OFF_STATUS);
        chk("tx off", {s[B_TXEMP], s[B_TXFR]}, 2'b00);
        $display("test tx done");
        // receive, including a character that lands while disabled
        ctl(C_RXEN);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            if (i == 3)
                ctl(C_RXDIS);
            ev({1'b1, v[9], v[8:0], 9'h000});
            ev(20'h00000);
            rreg(OFF_STATUS);
            chk("rx ready", {rx_enabled, s[B_RXAV]}, {2{i != 3}});
            if (i == 3)
                ctl(C_RXEN);
            rreg(OFF_STATUS);
            chk("rx ready on", s[B_RXAV], 1'b1);
            rreg(OFF_RX_HOLD);
            chk("rx holding", s, {16'h0, v[9], 6'h0, v[8:0]});
            rreg(OFF_STATUS);
            chk("rx ready off", s[B_RXAV], 1'b0);
        end
        $display("test rx done");
        results();
    end
endmodule : tb_top
